/* design/kta_pkg.sv */
// package: constants of the keypad tone and ring alerter
package kta_pkg;
   localparam int RES_HZ    = 480000;
   localparam int NROW      = 4;
   localparam int NCOL      = 3;
   localparam int HW        = 10;
   localparam int WW        = 14;
   localparam int ROW1_HZ   = 697;
   localparam int ROW2_HZ   = 770;
   localparam int ROW3_HZ   = 852;
   localparam int ROW4_HZ   = 941;
   localparam int COL1_HZ   = 1209;
   localparam int COL2_HZ   = 1336;
   localparam int COL3_HZ   = 1447;
   localparam int AL_LO_HZ  = 1800;
   localparam int AL_HI_HZ  = 2250;
   localparam int WARBLE_HZ = 20;
   localparam int DEB_US    = 2000;
   localparam int RSMP_US   = 1000;
   localparam int RING_CW   = 8;
   localparam int RING_UP   = 2;
   localparam int RING_ON   = 200;
   localparam int RING_OFF  = 8;
   localparam int AW        = 4;
   localparam logic [AW-1:0] CTRL_OFS   = 4'h0;
   localparam logic [AW-1:0] STAT_OFS   = 4'h4;
   localparam int            CTRL_TONE  = 0;
   localparam int            CTRL_ALERT = 1;
   localparam logic [1:0]    CTRL_RST   = 2'h3;
   localparam logic [1:0]    RESP_OKAY  = 2'h0;
   localparam logic [1:0]    RESP_SLVERR = 2'h2;

   // half period in resonator ticks, rounded to nearest
   function automatic logic [HW-1:0] half_of(input int hz);
      return HW'((RES_HZ + hz) / (2 * hz));
   endfunction : half_of

   localparam logic [NROW-1:0][HW-1:0] ROW_HALF = {half_of(ROW4_HZ),
      half_of(ROW3_HZ), half_of(ROW2_HZ), half_of(ROW1_HZ)};
   localparam logic [NCOL-1:0][HW-1:0] COL_HALF = {half_of(COL3_HZ),
      half_of(COL2_HZ), half_of(COL1_HZ)};
   localparam logic [HW-1:0] AL_LO_HALF  = half_of(AL_LO_HZ);
   localparam logic [HW-1:0] AL_HI_HALF  = half_of(AL_HI_HZ);
   localparam logic [WW-1:0] WARBLE_HALF = WW'(RES_HZ / (2 * WARBLE_HZ));
   localparam logic [HW-1:0] DEB_TICKS   =
      HW'(DEB_US * (RES_HZ / 1000) / 1000);
   localparam logic [HW-1:0] RSMP_TICKS  =
      HW'(RSMP_US * (RES_HZ / 1000) / 1000);
endpackage : kta_pkg

/* design/kta_sqgen.sv */
// square wave generator stepped by the resonator tick
`timescale 1ns/1ps
module kta_sqgen
   import kta_pkg::*;
#(
   parameter int W = HW
) (
   input  logic         sys_clk,
   input  logic         rst,
   input  logic         tick,
   input  logic         enable,
   input  logic [W-1:0] half_cnt,
   output logic         sq_out
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         sq;
   } kta_sq_s;

   kta_sq_s s_q;
   kta_sq_s s_d;

   always_comb begin
      s_d = s_q;
      if (!enable) begin
         s_d = '0;
      end else if (tick) begin
         if (s_q.cnt >= half_cnt - W'(1)) begin
            s_d.cnt = '0;
            s_d.sq  = ~s_q.sq;
         end else begin
            s_d.cnt = s_q.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sq_out = s_q.sq;

   property p_sq_edge;
      @(posedge sys_clk) disable iff (rst)
      enable && tick && s_q.cnt == half_cnt - W'(1)
      |=> enable && $changed(s_q.sq) || !enable;
   endproperty
   a_sq_edge: assert property (p_sq_edge)
      else $error("square wave missed its half period");
endmodule : kta_sqgen

/* design/kta_ringdet.sv */
// ringing detector: up/down counter with hysteresis
`timescale 1ns/1ps
module kta_ringdet
   import kta_pkg::*;
#(
   parameter int CW  = RING_CW,
   parameter int UP  = RING_UP,
   parameter int ON  = RING_ON,
   parameter int OFF = RING_OFF
) (
   input  logic sys_clk,
   input  logic rst,
   input  logic sample_tick,
   input  logic level_high,
   output logic ring_valid
);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          valid;
   } kta_rd_s;

   kta_rd_s s_q;
   kta_rd_s s_d;
   localparam logic [CW-1:0] MAXC = '1;

   always_comb begin
      s_d = s_q;
      if (sample_tick) begin
         if (level_high) begin
            s_d.cnt = (s_q.cnt > MAXC - CW'(UP)) ? MAXC : s_q.cnt + CW'(UP);
         end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - CW'(1);
         end
      end
      if (s_q.cnt >= CW'(ON)) begin
         s_d.valid = 1'b1;
      end else if (s_q.cnt <= CW'(OFF)) begin
         s_d.valid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign ring_valid = s_q.valid;

   property p_ring_on;
      @(posedge sys_clk) disable iff (rst)
      $rose(s_q.valid) |-> $past(s_q.cnt) >= CW'(ON);
   endproperty
   a_ring_on: assert property (p_ring_on)
      else $error("ringing declared below upper threshold");
endmodule : kta_ringdet

/* design/kta_top.sv */
// keypad tone selector, ring alerter and register slave
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module kta_top
   import kta_pkg::*;
(
   input  logic          sys_clk,
   input  logic          rst,
   input  logic          resonator_pin,
   input  logic          hook_speech_enable,
   input  logic          row_line_1,
   input  logic          row_line_2,
   input  logic          row_line_3,
   input  logic          row_line_4,
   input  logic          column_line_1,
   input  logic          column_line_2,
   input  logic          column_line_3,
   input  logic          ring_level_high,
   output logic          dual_tone_signalling_low,
   output logic          dual_tone_signalling_high,
   output logic          tone_to_tx,
   output logic          rx_attenuate,
   output logic          speech_enable,
   output logic          ring_valid,
   output logic          alerter_out_a,
   output logic          alerter_out_b,
   input  logic [AW-1:0] s_axi_awaddr,
   input  logic          s_axi_awvalid,
   output logic          s_axi_awready,
   input  logic [31:0]   s_axi_wdata,
   input  logic [3:0]    s_axi_wstrb,
   input  logic          s_axi_wvalid,
   output logic          s_axi_wready,
   output logic [1:0]    s_axi_bresp,
   output logic          s_axi_bvalid,
   input  logic          s_axi_bready,
   input  logic [AW-1:0] s_axi_araddr,
   input  logic          s_axi_arvalid,
   output logic          s_axi_arready,
   output logic [31:0]   s_axi_rdata,
   output logic [1:0]    s_axi_rresp,
   output logic          s_axi_rvalid,
   input  logic          s_axi_rready
);
   localparam int NK = NROW + NCOL;

   typedef struct packed {
      logic [1:0]      res_s;
      logic            res_prev;
      logic [1:0]      hk_s;
      logic [1:0]      rl_s;
      logic [NK-1:0]   key_s1;
      logic [NK-1:0]   key_s2;
      logic [NK-1:0]   smp;
      logic [NK-1:0]   stb;
      logic [HW-1:0]   deb;
      logic            low_on;
      logic            high_on;
      logic [1:0]      row_idx;
      logic [1:0]      col_idx;
      logic [HW-1:0]   rs_cnt;
      logic            rs_tick;
      logic [WW-1:0]   warb_cnt;
      logic            warb_sel;
      logic            tone_lo;
      logic            tone_hi;
      logic            tx_sel;
      logic            rx_att;
      logic            spk_en;
      logic            ring_o;
      logic            al_a;
      logic            al_b;
      logic [1:0]      ctrl;
      logic            aw_v;
      logic [AW-1:0]   aw_a;
      logic            w_v;
      logic [31:0]     w_d;
      logic            w_s;
      logic            awrdy;
      logic            wrdy;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            arrdy;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
   } kta_main_s;

   kta_main_s s_q;
   kta_main_s s_d;

   logic          res_tick;
   logic          hk;
   logic          lo_sq;
   logic          hi_sq;
   logic          al_sq;
   logic          ring_v;
   logic [HW-1:0] al_half;

   assign res_tick = s_q.res_s[1] & ~s_q.res_prev;
   assign hk       = s_q.hk_s[1];
   assign al_half  = s_q.warb_sel ? AL_HI_HALF : AL_LO_HALF;

   kta_sqgen #(.W(HW)) u_low (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .tick     (res_tick),
      .enable   (s_q.low_on),
      .half_cnt (ROW_HALF[s_q.row_idx]),
      .sq_out   (lo_sq)
   );

   kta_sqgen #(.W(HW)) u_high (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .tick     (res_tick),
      .enable   (s_q.high_on),
      .half_cnt (COL_HALF[s_q.col_idx]),
      .sq_out   (hi_sq)
   );

   kta_sqgen #(.W(HW)) u_alert (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .tick     (res_tick),
      .enable   (ring_v),
      .half_cnt (al_half),
      .sq_out   (al_sq)
   );

   kta_ringdet u_ring (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .sample_tick (s_q.rs_tick),
      .level_high  (s_q.rl_s[1]),
      .ring_valid  (ring_v)
   );

   always_comb begin
      logic [NK-1:0] act;
      logic [31:0]   stat;
      s_d = s_q;
      act = '0;
      stat = '0;
      // input synchronisers
      s_d.res_s    = {s_q.res_s[0], resonator_pin};
      s_d.res_prev = s_q.res_s[1];
      s_d.hk_s     = {s_q.hk_s[0], hook_speech_enable};
      s_d.rl_s     = {s_q.rl_s[0], ring_level_high};
      s_d.key_s1   = {column_line_3, column_line_2, column_line_1,
                      row_line_4, row_line_3, row_line_2, row_line_1};
      s_d.key_s2   = s_q.key_s1;
      // rows active low, columns active high
      if (hk) begin
         act = {s_q.key_s2[NK-1:NROW], ~s_q.key_s2[NROW-1:0]};
      end
      if (act != s_q.smp) begin
         s_d.smp = act;
         s_d.deb = '0;
      end else if (res_tick) begin
         if (s_q.deb == DEB_TICKS - HW'(1)) begin
            s_d.stb = s_q.smp;
         end else begin
            s_d.deb = s_q.deb + HW'(1);
         end
      end
      // a group sounds only while exactly one of its lines is active
      s_d.low_on  = hk && s_q.ctrl[CTRL_TONE] &&
         $countones(s_q.stb[NROW-1:0]) == 1;
      s_d.high_on = hk && s_q.ctrl[CTRL_TONE] &&
         $countones(s_q.stb[NK-1:NROW]) == 1;
      for (int i = 0; i < NROW; i++) begin
         if (s_q.stb[i]) begin
            s_d.row_idx = 2'(i);
         end
      end
      for (int j = 0; j < NCOL; j++) begin
         if (s_q.stb[NROW+j]) begin
            s_d.col_idx = 2'(j);
         end
      end
      // ringing sample pace
      s_d.rs_tick = 1'b0;
      if (res_tick) begin
         if (s_q.rs_cnt == RSMP_TICKS - HW'(1)) begin
            s_d.rs_cnt  = '0;
            s_d.rs_tick = 1'b1;
         end else begin
            s_d.rs_cnt = s_q.rs_cnt + HW'(1);
         end
      end
      // warble between the two alerter tones
      if (!ring_v) begin
         s_d.warb_cnt = '0;
         s_d.warb_sel = 1'b0;
      end else if (res_tick) begin
         if (s_q.warb_cnt == WARBLE_HALF - WW'(1)) begin
            s_d.warb_cnt = '0;
            s_d.warb_sel = ~s_q.warb_sel;
         end else begin
            s_d.warb_cnt = s_q.warb_cnt + WW'(1);
         end
      end
      s_d.tone_lo = lo_sq & s_q.low_on;
      s_d.tone_hi = hi_sq & s_q.high_on;
      s_d.tx_sel  = s_q.low_on | s_q.high_on;
      s_d.rx_att  = s_q.low_on | s_q.high_on;
      s_d.spk_en  = hk;
      s_d.ring_o  = ring_v & s_q.ctrl[CTRL_ALERT];
      s_d.al_a    = ring_v & s_q.ctrl[CTRL_ALERT] & al_sq;
      s_d.al_b    = ring_v & s_q.ctrl[CTRL_ALERT] & ~al_sq;
      // register slave: write side
      if (s_axi_awvalid && s_q.awrdy) begin
         s_d.aw_v = 1'b1;
         s_d.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wrdy) begin
         s_d.w_v = 1'b1;
         s_d.w_d = s_axi_wdata;
         s_d.w_s = s_axi_wstrb[0];
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_v && s_q.w_v && !s_q.bvalid) begin
         s_d.aw_v   = 1'b0;
         s_d.w_v    = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = RESP_OKAY;
         if (s_q.aw_a == CTRL_OFS) begin
            if (s_q.w_s) begin
               s_d.ctrl = s_q.w_d[1:0];
            end
         end else if (s_q.aw_a != STAT_OFS) begin
            s_d.bresp = RESP_SLVERR;
         end
      end
      s_d.awrdy = !s_d.aw_v && !s_d.bvalid;
      s_d.wrdy  = !s_d.w_v && !s_d.bvalid;
      // register slave: read side
      stat = {22'h0, s_q.col_idx, s_q.row_idx, s_q.warb_sel,
              s_q.high_on, s_q.low_on, ring_v, hk, 1'b0};
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arrdy) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = RESP_OKAY;
         s_d.rdata  = '0;
         if (s_axi_araddr == CTRL_OFS) begin
            s_d.rdata = {30'h0, s_q.ctrl};
         end else if (s_axi_araddr == STAT_OFS) begin
            s_d.rdata = stat;
         end else begin
            s_d.rresp = RESP_SLVERR;
         end
      end
      s_d.arrdy = !s_d.rvalid;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q      <= '0;
         s_q.ctrl <= CTRL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign dual_tone_signalling_low  = s_q.tone_lo;
   assign dual_tone_signalling_high = s_q.tone_hi;
   assign tone_to_tx    = s_q.tx_sel;
   assign rx_attenuate  = s_q.rx_att;
   assign speech_enable = s_q.spk_en;
   assign ring_valid    = s_q.ring_o;
   assign alerter_out_a = s_q.al_a;
   assign alerter_out_b = s_q.al_b;
   assign s_axi_awready = s_q.awrdy;
   assign s_axi_wready  = s_q.wrdy;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_arready = s_q.arrdy;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
   assign s_axi_rvalid  = s_q.rvalid;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   property p_onhook_quiet;
      !hk |=> !s_q.low_on && !s_q.high_on ##1 !dual_tone_signalling_low;
   endproperty
   a_onhook_quiet: assert property (p_onhook_quiet)
      else $error("tone selected while on hook");

   property p_col_only;
      hk && s_q.ctrl[CTRL_TONE] && $countones(s_q.stb[NK-1:NROW]) == 1
      && $countones(s_q.stb[NROW-1:0]) == 2 |=> s_q.high_on && !s_q.low_on;
   endproperty
   a_col_only: assert property (p_col_only)
      else $error("two rows on one column not column tone only");

   property p_row_only;
      hk && s_q.ctrl[CTRL_TONE] && $countones(s_q.stb[NROW-1:0]) == 1
      && $countones(s_q.stb[NK-1:NROW]) == 2 |=> s_q.low_on && !s_q.high_on;
   endproperty
   a_row_only: assert property (p_row_only)
      else $error("two columns on one row not row tone only");

   property p_diag;
      $countones(s_q.stb[NROW-1:0]) >= 2
      && $countones(s_q.stb[NK-1:NROW]) >= 2
      |=> !s_q.low_on && !s_q.high_on ##1 !tone_to_tx;
   endproperty
   a_diag: assert property (p_diag)
      else $error("diagonal keys produced a tone");

   property p_dual;
      hk && s_q.ctrl[CTRL_TONE] && s_q.stb == 7'b0010001
      |=> s_q.low_on && s_q.high_on && s_q.row_idx == 2'h0
      && s_q.col_idx == 2'h0;
   endproperty
   a_dual: assert property (p_dual)
      else $error("row 1 and column 1 did not give both tones");

   property p_stable;
      s_q.stb != $past(s_q.stb) |-> $past(s_q.deb) == DEB_TICKS - HW'(1)
      && $past(res_tick);
   endproperty
   a_stable: assert property (p_stable)
      else $error("key state committed before it was stable");

   property p_speech;
      hk != $past(hk) |=> speech_enable == $past(hk);
   endproperty
   a_speech: assert property (p_speech)
      else $error("speech enable does not follow hook contact");

   property p_dial_path;
      (s_q.low_on || s_q.high_on) |=> tone_to_tx && rx_attenuate;
   endproperty
   a_dial_path: assert property (p_dial_path)
      else $error("dialing tone without path switch");

   property p_antiphase;
      ring_valid |-> alerter_out_a != alerter_out_b;
   endproperty
   a_antiphase: assert property (p_antiphase)
      else $error("alerter outputs not in antiphase");

   property p_warble;
      ring_v && res_tick && s_q.warb_cnt == WARBLE_HALF - WW'(1)
      |=> s_q.warb_sel != $past(s_q.warb_sel);
   endproperty
   a_warble: assert property (p_warble)
      else $error("alerter tone did not switch on time");

   property p_res_pace;
      s_q.rs_tick |-> $past(res_tick)
      && $past(s_q.rs_cnt) == RSMP_TICKS - HW'(1);
   endproperty
   a_res_pace: assert property (p_res_pace)
      else $error("ring sample pace not from resonator");

   c_dual: cover property (s_q.low_on && s_q.high_on);
   c_ring: cover property ($rose(ring_valid));
   c_warb: cover property (ring_v && $changed(s_q.warb_sel));
   c_diag: cover property (s_q.stb == 7'b0110011);
endmodule : kta_top

/* tb/kta_keypad_model.sv */
// keypad switch matrix, with optional processor drive of the lines
`timescale 1ns/1ps
module kta_keypad_model
   import kta_pkg::*;
(
   input  logic [NROW*NCOL-1:0] keys,
   input  logic [NROW-1:0]      cpu_row_low,
   input  logic [NCOL-1:0]      cpu_col_high,
   output logic                 row_line_1,
   output logic                 row_line_2,
   output logic                 row_line_3,
   output logic                 row_line_4,
   output logic                 column_line_1,
   output logic                 column_line_2,
   output logic                 column_line_3
);
   logic [NROW-1:0] row_hit;
   logic [NCOL-1:0] col_hit;

   // a closed key joins its row to its column
   always_comb begin
      row_hit = cpu_row_low;
      col_hit = cpu_col_high;
      for (int r = 0; r < NROW; r++) begin
         for (int c = 0; c < NCOL; c++) begin
            if (keys[r*NCOL+c]) begin
               row_hit[r] = 1'b1;
               col_hit[c] = 1'b1;
            end
         end
      end
   end

   // selected rows read low, selected columns read high
   assign row_line_1    = ~row_hit[0];
   assign row_line_2    = ~row_hit[1];
   assign row_line_3    = ~row_hit[2];
   assign row_line_4    = ~row_hit[3];
   assign column_line_1 = col_hit[0];
   assign column_line_2 = col_hit[1];
   assign column_line_3 = col_hit[2];
endmodule : kta_keypad_model

/* tb/keypad_tone_and_ring_alerter_tb.sv */
// self-checking bench for the keypad tone and ring alerter
`timescale 1ns/1ps
module keypad_tone_and_ring_alerter_tb
   import kta_pkg::*;
;
   logic sys_clk = 1'b0;
   logic resonator_pin = 1'b0;
   logic rst, hook_speech_enable, ring_level_high, ten;
   logic row_line_1, row_line_2, row_line_3, row_line_4;
   logic column_line_1, column_line_2, column_line_3;
   logic dual_tone_signalling_low, dual_tone_signalling_high;
   logic tone_to_tx, rx_attenuate, speech_enable, ring_valid;
   logic alerter_out_a, alerter_out_b;
   logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]   s_axi_wdata, s_axi_rdata, xs_st;
   logic [3:0]    s_axi_wstrb, cpu_rl;
   logic [1:0]    s_axi_bresp, s_axi_rresp, tones;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [11:0]   keys;
   logic [2:0]    cpu_ch;
   int            errors, checked, prev;
   int            row_hz[4] = '{ROW1_HZ, ROW2_HZ, ROW3_HZ, ROW4_HZ};
   int            col_hz[3] = '{COL1_HZ, COL2_HZ, COL3_HZ};

   kta_top u_dut (.sys_clk, .rst, .resonator_pin, .hook_speech_enable,
      .row_line_1, .row_line_2, .row_line_3, .row_line_4, .column_line_1,
      .column_line_2, .column_line_3, .ring_level_high,
      .dual_tone_signalling_low, .dual_tone_signalling_high, .tone_to_tx,
      .rx_attenuate, .speech_enable, .ring_valid, .alerter_out_a,
      .alerter_out_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   kta_keypad_model u_pad (.keys, .cpu_row_low(cpu_rl), .cpu_col_high(cpu_ch),
      .row_line_1, .row_line_2, .row_line_3, .row_line_4, .column_line_1,
      .column_line_2, .column_line_3);

   assign tones = {dual_tone_signalling_high, dual_tone_signalling_low};
   always #2.5 sys_clk = ~sys_clk;
   // fast resonator: one tick every two clocks keeps runs short
   always @(posedge sys_clk) resonator_pin <= ~resonator_pin;

   function automatic logic [31:0] xs();
      xs_st ^= xs_st << 13;
      xs_st ^= xs_st >> 17;
      xs_st ^= xs_st << 5;
      return xs_st;
   endfunction : xs

   // half period in clocks, two clocks per resonator tick
   function automatic int half2(input int f);
      return 2 * ((RES_HZ + f) / (2 * f));
   endfunction : half2

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string msg);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t %s: got %0h exp %0h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic axi_wr(input logic [AW-1:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      int n;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      r = 2'h1;
      for (n = 0; n < 64; n++) begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (n == 64) chk(0, 1, "write hang");
   endtask : axi_wr

   task automatic axi_rd(input logic [AW-1:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r = 2'h1;
      d = 32'h0;
      for (n = 0; n < 64; n++) begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (n == 64) chk(0, 1, "read hang");
   endtask : axi_rd

   // clocks between two toggles of one tone pin, 0 if it stays still
   task automatic meas(input int sel, output int h);
      logic v;
      int n;
      h = 0;
      v = tones[sel];
      for (n = 0; n < 800 && tones[sel] === v; n++) @(posedge sys_clk);
      if (n == 800) return;
      v = tones[sel];
      for (n = 0; n < 800 && tones[sel] === v; n++) @(posedge sys_clk);
      if (n < 800) h = n;
   endtask : meas

   task automatic run_case(input logic [11:0] k, input logic [3:0] rl,
                           input logic [2:0] ch);
      int nr, nc, ri, ci, h;
      logic lo, hi;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge sys_clk);
      keys <= k;
      cpu_rl <= rl;
      cpu_ch <= ch;
      {nr, nc, ri, ci} = '0;
      for (int a = 0; a < 4; a++) if (rl[a] || k[a*3+:3] != 0) begin
         nr++;
         ri = a;
      end
      for (int b = 0; b < 3; b++)
         if (ch[b] || {k[b], k[b+3], k[b+6], k[b+9]} != 0) begin
            nc++;
            ci = b;
         end
      lo = nr == 1 && hook_speech_enable;
      hi = nc == 1 && hook_speech_enable;
      repeat (int'(DEB_TICKS)) @(posedge sys_clk);
      if (ten) chk(tone_to_tx, prev, "early change");
      repeat (int'(DEB_TICKS) + 40) @(posedge sys_clk);
      meas(0, h);
      chk(h, lo && ten ? half2(row_hz[ri]) : 0, "low tone");
      meas(1, h);
      chk(h, hi && ten ? half2(col_hz[ci]) : 0, "hi tone");
      chk(speech_enable, hook_speech_enable, "speech");
      if (ten) begin
         chk({tone_to_tx, rx_attenuate}, {2{lo | hi}}, "tx path");
         axi_rd(STAT_OFS, d, r);
         chk(d[4:1], {hi, lo, 1'b0, hook_speech_enable}, "status");
         prev = lo | hi;
      end
      $display("case keys %h rows %h cols %h done", k, rl, ch);
   endtask : run_case

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (100000) @(posedge sys_clk);
      chk(0, 1, "watchdog");
      complete_run();
   end

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int i, bad;
      {rst, hook_speech_enable, ten} = 3'h7;
      {ring_level_high, keys, cpu_rl, cpu_ch} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_wstrb = 4'hf;
      xs_st = 32'h0000cb46;
      {errors, checked, prev} = '0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      axi_rd(CTRL_OFS, d, r);
      chk(d, {30'h0, CTRL_RST}, "ctrl reset");
      axi_rd(4'h8, d, r);
      chk({r, d[29:0]}, {RESP_SLVERR, 30'h0}, "unmapped read");
      axi_wr(4'h8, xs(), r);
      chk(r, RESP_SLVERR, "unmapped write");
      axi_wr(STAT_OFS, xs(), r);
      chk(r, RESP_OKAY, "status write");
      axi_wr(CTRL_OFS, xs() | 32'h3, r);
      axi_rd(CTRL_OFS, d, r);
      chk(d, 32'h3, "ctrl store");
      $display("register test done");
      for (i = 0; i < 12; i++) run_case(12'(1 << i), 4'h0, 3'h0);
      @(posedge sys_clk);
      hook_speech_enable <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk(tones, 2'h0, "hook drop");
      prev = 0;
      run_case(12'h040, 4'h0, 3'h0);
      run_case(12'h000, 4'h0, 3'h0);
      @(posedge sys_clk);
      hook_speech_enable <= 1'b1;
      run_case(12'h009, 4'h0, 3'h0);
      run_case(12'h003, 4'h0, 3'h0);
      run_case(12'h011, 4'h0, 3'h0);
      run_case(12'h000, 4'h0, 3'h4);
      run_case(12'h000, 4'h8, 3'h0);
      for (i = 0; i < 2; i++)
         run_case(12'(1 << (xs() % 12)) | 12'(1 << (xs() % 12)), 4'h0, 3'h0);
      @(posedge sys_clk);
      ring_level_high <= 1'b1;
      bad = 0;
      repeat (16 * int'(RSMP_TICKS)) begin
         @(posedge sys_clk);
         if ({ring_valid, alerter_out_a, alerter_out_b} !== 3'h0) bad++;
      end
      ring_level_high <= 1'b0;
      chk(bad, 0, "short burst");
      axi_rd(STAT_OFS, d, r);
      chk(d[2], 1'b0, "ring status");
      $display("ring burst test done");
      axi_wr(CTRL_OFS, 32'h2, r);
      ten = 1'b0;
      run_case(12'h010, 4'h0, 3'h0);
      complete_run();
   end
endmodule : keypad_tone_and_ring_alerter_tb
